// [include/udp_pkg.sv]
// package for the serial data port block: offsets, fields, types
package udp_pkg;
	// register byte addresses
	localparam logic [11:0] ADDR_DATA = 12'h000;
	localparam logic [11:0] ADDR_CTRL = 12'h004;
	localparam logic [11:0] ADDR_STAT = 12'h008;
	localparam logic [11:0] ADDR_MASK = 12'h00C;
	// data register fields
	localparam int BIT_NOISE = 15;
	localparam int BIT_PERR = 14;
	localparam int BIT_FESC = 13;
	localparam int BIT_EMPTY = 12;
	localparam int BIT_T9 = 9;
	// control fields
	localparam int BIT_PEN = 0;
	localparam int BIT_PODD = 1;
	localparam int BIT_NINE = 2;
	// status / mask fields
	localparam int EV_RX = 0;
	localparam int EV_TXDONE = 1;
	localparam int EV_OVR = 2;
	localparam int EV_ERR = 3;
	localparam int NUM_EV = 4;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [3:0] MASK_RST = 4'h0;
	// timing
	localparam int CLK_HZ = 20000000;
	localparam int BAUD = 115200;
	localparam int BIT_CYC = CLK_HZ / BAUD;
	localparam int BRK_BITS = 13;
	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} udp_tx_e;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} udp_rx_e;
	typedef struct packed {
		logic noise;
		logic perr;
		logic ferr;
		logic [8:0] data;
	} udp_rxword_s;
endpackage : udp_pkg

// [design/udp_serial_data_port.sv]
// serial port data register with parity, apb slave and simple tx/rx shifters
// How it works
// R1: parity enable turns generation and checking on
// R2: parity type: 0 even, 1 odd
// R3: ones count including parity matches type
// R4: reads give rx buffer, writes load tx
// R5: data reads/writes clear related status flags
// R6: bits 31..16 read zero, writes ignored
// R7: bit 15 reports noise of buffered word
// R8: bit 14 reports parity error of word
// R9: bit 13 reports frame error on read
// R10: write bit 13 sends special character
// R11: bit 9 picks break (0) or idle (1)
// R12: software zeroes bits 8..0 for special
// R13: bit 12 set when rx buffer empty
// R14: empty ignores word still in shifter
// R15: software ignores data when empty set
// R16: parity bit sits just before stop bit
// R17: eight or nine bit characters both directions
// R18: error flags travel with their word
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/100ps
module udp_serial_data_port
	import udp_pkg::*;
#(
	parameter int BIT_CYCLES = BIT_CYC
) (
	input wire logic sys_clk, // 20 MHz clock
	input wire logic nrst, // sync reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic rxd, // serial input
	output logic txd, // serial output
	output logic irq // level interrupt
);
	// ==========================================
	// bus decode
	wire logic acc = psel && penable && !pready;
	wire logic hitData = (paddr == ADDR_DATA);
	wire logic hitCtrl = (paddr == ADDR_CTRL);
	wire logic hitStat = (paddr == ADDR_STAT);
	wire logic hitMask = (paddr == ADDR_MASK);
	wire logic hitAny = hitData || hitCtrl || hitStat || hitMask;
	wire logic wrData = acc && pwrite && hitData;
	wire logic rdData = acc && !pwrite && hitData;
	wire logic rdStat = acc && !pwrite && hitStat;

	logic [2:0] ctrl_r;
	logic [NUM_EV-1:0] stat_r;
	logic [NUM_EV-1:0] mask_r;
	udp_rxword_s rxBuf_r;
	logic rxFull_r;
	wire logic parEn = ctrl_r[BIT_PEN]; // R1
	wire logic parOdd = ctrl_r[BIT_PODD]; // R2
	wire logic nine = ctrl_r[BIT_NINE]; // R17
	wire logic [3:0] nBits = nine ? 4'd9 : 4'd8; // R17

	// ==========================================
	// transmitter
	udp_tx_e txSt_r;
	logic [8:0] txSh_r;
	logic [3:0] txCnt_r;
	logic [15:0] txTim_r;
	logic txPar_r;
	logic txSpec_r;
	logic txBrk_r;
	logic txBusy_r;
	logic txEvt_r;
	wire logic txTick = (txTim_r == 16'(BIT_CYCLES - 1));
	wire logic txStart = wrData && !txBusy_r;
	wire logic txOvr = wrData && txBusy_r;
	wire logic [8:0] txLoad = nine ? pwdata[8:0] : {1'b0, pwdata[7:0]};
	// R3: xor of data plus odd selector gives ones count parity
	wire logic txParNew = (^txLoad) ^ parOdd;
	// special characters last a whole frame of break or idle bits
	wire logic [3:0] specBits = 4'(BRK_BITS);
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			txSt_r <= TX_IDLE;
			txSh_r <= 9'h0;
			txCnt_r <= 4'h0;
			txTim_r <= 16'h0;
			txPar_r <= 1'b0;
			txSpec_r <= 1'b0;
			txBrk_r <= 1'b0;
			txBusy_r <= 1'b0;
			txEvt_r <= 1'b0;
			txd <= 1'b1;
		end else begin
			txEvt_r <= 1'b0;
			txTim_r <= (txSt_r == TX_IDLE || txTick) ? 16'h0 : txTim_r + 16'h1;
			case (txSt_r)
				TX_IDLE: begin
					txd <= 1'b1;
					if (txStart) begin // R4
						txBusy_r <= 1'b1;
						txSh_r <= txLoad;
						txPar_r <= txParNew; // R3
						txSpec_r <= pwdata[BIT_FESC]; // R10
						txBrk_r <= !pwdata[BIT_T9]; // R11
						txCnt_r <= 4'h0;
						txSt_r <= TX_START;
						txd <= pwdata[BIT_FESC] ? pwdata[BIT_T9] : 1'b0; // R10 R11
					end
				end
				TX_START: if (txTick) begin
					txCnt_r <= 4'h0;
					if (txSpec_r) begin
						txSt_r <= TX_DATA;
					end else begin
						txSt_r <= TX_DATA;
						txd <= txSh_r[0];
						txSh_r <= txSh_r >> 1;
					end
				end
				TX_DATA: if (txTick) begin
					txCnt_r <= txCnt_r + 4'h1;
					if (txSpec_r) begin
						if (txCnt_r == specBits - 4'd2) begin
							txSt_r <= TX_STOP;
							txd <= 1'b1;
						end
					end else if (txCnt_r == nBits - 4'd1) begin
						txSt_r <= parEn ? TX_PAR : TX_STOP; // R1 R16
						txd <= parEn ? txPar_r : 1'b1; // R16
					end else begin
						txd <= txSh_r[0];
						txSh_r <= txSh_r >> 1;
					end
				end
				TX_PAR: if (txTick) begin
					txSt_r <= TX_STOP;
					txd <= 1'b1;
				end
				default: if (txTick) begin
					txSt_r <= TX_IDLE;
					txBusy_r <= 1'b0;
					txEvt_r <= 1'b1;
				end
			endcase
		end
	end
	wire logic unusedBrk = txBrk_r;

	// ==========================================
	// receiver: majority of three samples mid-bit, disagreement marks noise
	udp_rx_e rxSt_r;
	logic [8:0] rxSh_r;
	logic [3:0] rxCnt_r;
	logic [15:0] rxTim_r;
	logic [2:0] smp_r;
	logic rxNoise_r;
	logic rxPar_r;
	logic rxPerr_r;
	logic rxDone_r;
	udp_rxword_s rxNew_r;
	wire logic maj = (smp_r[0] & smp_r[1]) | (smp_r[1] & smp_r[2]) | (smp_r[0] & smp_r[2]);
	wire logic disagree = !(&smp_r) && (|smp_r);
	wire logic rxMid = (rxTim_r == 16'(BIT_CYCLES / 2 + 1));
	wire logic rxEnd = (rxTim_r == 16'(BIT_CYCLES - 1));
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rxSt_r <= RX_IDLE;
			rxSh_r <= 9'h0;
			rxCnt_r <= 4'h0;
			rxTim_r <= 16'h0;
			smp_r <= 3'h7;
			rxNoise_r <= 1'b0;
			rxPar_r <= 1'b0;
			rxPerr_r <= 1'b0;
			rxDone_r <= 1'b0;
			rxNew_r <= '0;
		end else begin
			rxDone_r <= 1'b0;
			smp_r <= {smp_r[1:0], rxd};
			rxTim_r <= (rxSt_r == RX_IDLE || rxEnd) ? 16'h0 : rxTim_r + 16'h1;
			if (rxMid && disagree && rxSt_r != RX_IDLE) begin
				rxNoise_r <= 1'b1;
			end
			case (rxSt_r)
				RX_IDLE: if (!rxd) begin
					rxSt_r <= RX_START;
					rxNoise_r <= 1'b0;
					rxPar_r <= parOdd; // R2
					rxCnt_r <= 4'h0;
					rxSh_r <= 9'h0;
				end
				RX_START: if (rxMid && maj) begin
					rxSt_r <= RX_IDLE;
				end else if (rxEnd) begin
					rxSt_r <= RX_DATA;
				end
				RX_DATA: begin
					if (rxMid) begin
						rxSh_r <= nine ? {maj, rxSh_r[8:1]} : {1'b0, maj, rxSh_r[7:1]}; // R17
						rxPar_r <= rxPar_r ^ maj; // R3
					end
					if (rxEnd) begin
						rxCnt_r <= rxCnt_r + 4'h1;
						if (rxCnt_r == nBits - 4'd1) begin
							rxSt_r <= parEn ? RX_PAR : RX_STOP; // R1 R16
						end
					end
				end
				RX_PAR: begin
					if (rxMid) begin
						rxPerr_r <= rxPar_r ^ maj; // R3
					end
					if (rxEnd) begin
						rxSt_r <= RX_STOP;
					end
				end
				default: if (rxMid) begin
					rxSt_r <= RX_IDLE;
					rxDone_r <= 1'b1;
					rxNew_r.data <= rxSh_r;
					rxNew_r.ferr <= !maj; // R9
					rxNew_r.perr <= parEn && rxPerr_r; // R1 R8
					rxNew_r.noise <= rxNoise_r || disagree; // R7
					rxPerr_r <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================
	// receive buffer, flags held with their word
	wire logic rxTake = rdData && rxFull_r;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rxBuf_r <= '0;
			rxFull_r <= 1'b0;
		end else if (rxDone_r) begin
			if (!rxFull_r || rxTake) begin
				rxBuf_r <= rxNew_r; // R18
				rxFull_r <= 1'b1; // R14
			end
		end else if (rxTake) begin
			rxFull_r <= 1'b0; // R13
		end
	end

	// ==========================================
	// registers, status and interrupt
	wire logic [NUM_EV-1:0] evNow = {
		rxDone_r && (rxNew_r.perr || rxNew_r.ferr || rxNew_r.noise),
		rxDone_r && rxFull_r && !rxTake,
		txEvt_r,
		rxDone_r
	};
	// an empty buffer reads as zero apart from the empty bit
	wire udp_rxword_s rxShow = rxFull_r ? rxBuf_r : '0;
	wire logic [31:0] dataRd = {16'h0, rxShow.noise, rxShow.perr, rxShow.ferr, // R6 R7 R8 R9
		!rxFull_r, 3'h0, rxShow.data}; // R13
	wire logic [31:0] rdMux = hitData ? dataRd :
		hitCtrl ? {29'h0, ctrl_r} :
		hitStat ? {28'h0, stat_r} :
		hitMask ? {28'h0, mask_r} : 32'h0;
	// R5: data read clears rx event, data write clears tx-done event
	wire logic [NUM_EV-1:0] dataClr = {1'b0, rdData, wrData, rdData};
	wire logic [NUM_EV-1:0] statNxt = evNow | (stat_r & ~(rdStat ? stat_r : dataClr));
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl_r <= CTRL_RST;
			mask_r <= MASK_RST;
			stat_r <= '0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end else begin
			pready <= acc;
			pslverr <= acc && !hitAny;
			prdata <= (acc && !pwrite) ? rdMux : 32'h0; // R4
			if (acc && pwrite && hitCtrl) begin
				ctrl_r <= pwdata[2:0];
			end
			if (acc && pwrite && hitMask) begin
				mask_r <= pwdata[NUM_EV-1:0];
			end
			stat_r <= statNxt; // R5
			irq <= |(statNxt & mask_r);
		end
	end
	wire logic unusedOvr = txOvr;

	// ==========================================
	// checks
	property p_empty_flag;
		@(posedge sys_clk) disable iff (!nrst)
		(rdData && !rxDone_r && !rxFull_r) |=> prdata[BIT_EMPTY];
	endproperty
	a_empty_flag: assert property (p_empty_flag) else $error("empty bit not set"); // R13
	property p_reserved_zero;
		@(posedge sys_clk) disable iff (!nrst) pready |-> prdata[31:16] == 16'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("upper bits nonzero"); // R6
	property p_take_clears;
		@(posedge sys_clk) disable iff (!nrst) (rxTake && !rxDone_r) |=> !rxFull_r;
	endproperty
	a_take_clears: assert property (p_take_clears) else $error("read did not empty"); // R13
	property p_fill;
		@(posedge sys_clk) disable iff (!nrst) rxDone_r |=> rxFull_r;
	endproperty
	a_fill: assert property (p_fill) else $error("word not buffered"); // R14
	property p_noparity;
		@(posedge sys_clk) disable iff (!nrst) (rxDone_r && !parEn) |-> !rxNew_r.perr;
	endproperty
	a_noparity: assert property (p_noparity) else $error("parity checked while off"); // R1
	property p_txstart;
		@(posedge sys_clk) disable iff (!nrst)
		(txStart && !pwdata[BIT_FESC]) |=> !txd && txSt_r == TX_START;
	endproperty
	a_txstart: assert property (p_txstart) else $error("no start bit"); // R10
	property p_idle_char;
		@(posedge sys_clk) disable iff (!nrst)
		(txStart && pwdata[BIT_FESC] && pwdata[BIT_T9]) |=> txd [*3];
	endproperty
	a_idle_char: assert property (p_idle_char) else $error("idle char not high"); // R11
	property p_stat_rx;
		@(posedge sys_clk) disable iff (!nrst) rxDone_r |=> stat_r[EV_RX];
	endproperty
	a_stat_rx: assert property (p_stat_rx) else $error("rx event lost"); // R5
	property p_empty_fields;
		@(posedge sys_clk) disable iff (!nrst)
		(rdData && !rxFull_r) |=> prdata[15:13] == 3'h0 && prdata[8:0] == 9'h0;
	endproperty
	a_empty_fields: assert property (p_empty_fields) else $error("stale word on empty read"); // R7
	property p_txdone;
		@(posedge sys_clk) disable iff (!nrst)
		(txSt_r == TX_STOP && txTick) |-> ##2 stat_r[EV_TXDONE];
	endproperty
	a_txdone: assert property (p_txdone) else $error("tx done event lost"); // R5

	// ==========================================
	// special-character sequences
	sequence s_break_write;
		txStart && pwdata[BIT_FESC] && !pwdata[BIT_T9];
	endsequence
	sequence s_line_low;
		!txd [*3];
	endsequence
	property p_break_char;
		@(posedge sys_clk) disable iff (!nrst) s_break_write |=> s_line_low;
	endproperty
	a_break_char: assert property (p_break_char) else $error("break char not low"); // R11
endmodule : udp_serial_data_port

// [test/udp_far_end.sv]
// far-end serial partner: sends frames on rxd and captures frames from txd
`timescale 1ns/100ps
module udp_far_end #(
	parameter int BC = 8
) (
	input wire logic sys_clk, // bench clock
	input wire logic txd, // line from the port
	output logic rxd // line into the port
);
	logic [10:0] seen = '1;
	int frames = 0;
	initial rxd = 1'b1;
	// ==========
	// capture: eleven mid-bit samples after each start bit
	always begin
		@(negedge txd);
		repeat (BC / 2) @(posedge sys_clk);
		for (int i = 0; i < 11; i++) begin
			repeat (BC) @(posedge sys_clk);
			seen[i] = txd;
		end
		frames++;
	end
	// ==========
	// send: start bit, eleven bits lsb first, then idle high
	task automatic send(input logic [10:0] f);
		rxd <= 1'b0;
		repeat (BC) @(posedge sys_clk);
		for (int i = 0; i < 11; i++) begin
			rxd <= f[i];
			repeat (BC) @(posedge sys_clk);
		end
		rxd <= 1'b1;
	endtask : send
endmodule : udp_far_end

// [test/udp_serial_data_port_tb_top.sv]
// self-checking bench for the serial data port block
`timescale 1ns/100ps
module udp_serial_data_port_tb_top
	import udp_pkg::*;
;
	localparam int BC = 8;
	logic sysClk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rdat, rnd;
	logic pready, pslverr, rxd, txd, irq, rerr, bp, bs;
	logic [31:0] seed = 32'h0000_A2BD;
	logic [10:0] f;
	logic [2:0] c;
	int fails = 0;
	int totalChecks = 0;
	int cyc = 0;
	int n, fr;
	always #25 sysClk = ~sysClk;
	udp_serial_data_port #(.BIT_CYCLES(BC)) u_dut (.sys_clk(sysClk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
	udp_far_end #(.BC(BC)) u_far (.sys_clk(sysClk), .txd(txd), .rxd(rxd));
	// ==========
	// expectations
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [10:0] exp_frame(input logic [8:0] d, input logic [2:0] c);
		logic [10:0] r;
		logic p;
		int m;
		m = c[BIT_NINE] ? 9 : 8;
		r = '1;
		p = c[BIT_PODD];
		for (int i = 0; i < m; i++) begin
			r[i] = d[i];
			p = p ^ d[i];
		end
		if (c[BIT_PEN]) r[m] = p;
		return r;
	endfunction : exp_frame
	function automatic logic [31:0] exp_rx(input logic [8:0] d, input logic [2:0] c,
		input logic bp, input logic bs);
		return {16'h0000, 1'b0, c[BIT_PEN] & bp, bs, 4'h0, c[BIT_NINE] & d[8], d[7:0]};
	endfunction : exp_rx
	// ==========
	// bus and check tasks
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sysClk);
		penable <= 1'b1;
		do begin
			@(posedge sysClk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sysClk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, rdat, e);
	endtask : rd
	task automatic txw(input logic [31:0] w);
		int k;
		k = 0;
		fr = u_far.frames;
		apb(1'b1, ADDR_DATA, w);
		while (u_far.frames == fr && k < 300) begin
			@(posedge sysClk);
			k++;
		end
		if (k == 300 && !w[BIT_FESC]) fails++;
		repeat (3 * BC) @(posedge sysClk);
	endtask : txw
	task automatic final_report();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	always @(posedge sysClk) begin
		cyc++;
		if (cyc == 12000) begin
			fails++;
			final_report();
		end
	end
	// ==========
	// main sequence
	initial begin
		repeat (10) @(posedge sysClk);
		nrst <= 1'b1;
		@(posedge sysClk);
		rd(ADDR_CTRL, {29'h0, CTRL_RST}, "ctrl reset");
		rd(ADDR_MASK, {28'h0, MASK_RST}, "mask reset");
		rd(ADDR_DATA, 32'h0000_1000, "data reset");
		rd(12'h010, 32'h0000_0000, "unmapped");
		chk("slverr", {31'h0, rerr}, 32'h0000_0001);
		for (int k = 0; k < 8; k++) begin
			c = k[2:0];
			rnd = xs();
			n = c[BIT_NINE] ? 9 : 8;
			bp = rnd[20] & c[BIT_PEN];
			bs = rnd[21];
			apb(1'b1, ADDR_MASK, {31'h0, k[0]});
			apb(1'b1, ADDR_CTRL, {29'h0, c});
			rd(ADDR_CTRL, {29'h0, c}, "ctrl");
			apb(1'b0, ADDR_STAT, 32'h0000_0000);
			f = exp_frame(rnd[8:0], c);
			if (bp) f[n] = ~f[n];
			if (bs) f[n + int'(c[BIT_PEN])] = 1'b0;
			fork
				u_far.send(f);
				begin
					repeat (4 * BC) @(posedge sysClk);
					rd(ADDR_DATA, 32'h0000_1000, "empty mid frame");
				end
			join
			repeat (3 * BC) @(posedge sysClk);
			chk("irq set", {31'h0, irq}, {31'h0, k[0]});
			rd(ADDR_DATA, exp_rx(rnd[8:0], c, bp, bs), "rx word");
			rd(ADDR_DATA, 32'h0000_1000, "rx empty");
			repeat (2) @(posedge sysClk);
			chk("irq clear", {31'h0, irq}, 32'h0000_0000);
			rnd = xs();
			txw({rnd[31:16], 7'h00, rnd[8:0]});
			chk("tx frame", {21'h0, u_far.seen}, {21'h0, exp_frame(rnd[8:0], c)});
		end
		txw(32'h0000_2000);
		chk("break", {21'h0, u_far.seen}, 32'h0000_0000);
		txw(32'h0000_2200);
		chk("idle frames", 32'(u_far.frames), 32'(fr));
		final_report();
	end
endmodule : udp_serial_data_port_tb_top
